//--- pkg/tepb_pkg.sv
package tepb_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [5:0]  IDX_VECTOR_BASE    = 6'h00;
  localparam logic [5:0]  IDX_SAVED_STATUS   = 6'h01;
  localparam logic [5:0]  IDX_CURRENT_STATUS = 6'h02;
  localparam logic [5:0]  IDX_TRAP_STATE     = 6'h03;
  localparam logic [5:0]  IDX_DECODE_PC      = 6'h0A;
  localparam logic [5:0]  IDX_EXECUTE_PC     = 6'h0B;
  localparam logic [5:0]  IDX_WRITEBACK_PC   = 6'h0C;

  // Current status fields
  localparam int          DA_BIT             = 0;
  localparam int          DI_BIT             = 1;
  localparam int          FZ_BIT             = 10;
  localparam logic [31:0] STATUS_RESET       = 32'h0000_0413;
  // Handler status pattern: bits in KEEP stay, SET bits forced on
  localparam logic [31:0] HANDLER_KEEP_MASK  = 32'hFFFF_F800;
  localparam logic [31:0] HANDLER_SET_MASK   = 32'h0000_0413;
  localparam logic [31:0] VECTOR_BASE_MASK   = 32'hFFFF_FC00;

  // Vector numbers
  localparam logic [7:0]  VEC_ILLEGAL        = 8'h00;
  localparam logic [7:0]  VEC_TLB_BASE       = 8'h08;
  localparam logic [7:0]  VEC_IMMU_PROT      = 8'h0C;
  localparam logic [7:0]  VEC_DMMU_PROT      = 8'h0D;
  localparam logic [7:0]  VEC_PIN_BASE       = 8'h10;
  localparam logic [7:0]  VEC_FP_EXCEPTION   = 8'h16;
  localparam logic [7:0]  VEC_EMUL_FIRST     = 8'h18;
  localparam logic [7:0]  VEC_EMUL_LAST      = 8'h3F;
  localparam logic [7:0]  VEC_INSTR_FIRST    = 8'h40;
  localparam logic [7:0]  EMUL_OPCODE_FIRST  = 8'hD8;
  localparam logic [7:0]  EMUL_OPCODE_OFFSET = 8'hC0;

  localparam int          PIN_COUNT          = 6;
  localparam logic [2:0]  PIN_SHARED_IDX     = 3'd3;

  typedef enum logic [7:0] {
    TEPB_IDLE       = 8'h01,
    TEPB_SUSP_EXEC  = 8'h02,
    TEPB_SUSP_FETCH = 8'h04,
    TEPB_WAIT_MEM   = 8'h08,
    TEPB_COPY       = 8'h10,
    TEPB_MODIFY     = 8'h20,
    TEPB_VEC_READ   = 8'h40,
    TEPB_FETCH      = 8'h80
  } tepb_state_t;

endpackage

//--- design/tepb_stage_reg.sv
`timescale 1ns/1ps
module tepb_stage_reg (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        stage_enter,
  input  wire logic [31:0] stage_addr,
  input  wire logic        freeze_bit,
  input  wire logic        sw_write,
  input  wire logic [31:0] sw_data,
  output logic      [31:0] value
);

  typedef struct packed {
    logic [29:0] word_addr;
  } tepb_stage_t;

  tepb_stage_t state_reg;
  tepb_stage_t state_next;

  always_comb begin
    state_next = state_reg;
    // Software load wins so a handler can set restart points while frozen
    if (sw_write) begin
      state_next.word_addr = sw_data[31:2];
    end else if (stage_enter && !freeze_bit) begin
      state_next.word_addr = stage_addr[31:2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value = {state_reg.word_addr, 2'b00};

endmodule // tepb_stage_reg

//--- design/tepb_trap_entry.sv
`timescale 1ns/1ps
// Overview of operation
// RL1: TLB misses 8-11, MMU protection 12, 13
// RL2: Interrupt pins 16-19, trap pins 20-21
// RL3: Unimplemented opcodes trap to vectors 24-63
// RL4: Vectors 64-255 come from instruction field
// RL5: Withdrawn pin request yields illegal-opcode vector
// RL6: Hardware never raises vector 22
// RL7: Restart execute address first, decode second
// RL8: Write-back address unused for return
// RL9: Live fetch counter not visible to software
// RL10: Decode address captured unless frozen
// RL11: Execute address captured unless frozen
// RL12: Write-back address captured unless frozen
// RL13: Low two address bits read zero
// RL14: Suspend execute, fetch, finish memory, cancel multiple
// RL15: Copy status to saved, then modify
// RL16: Set freeze; frozen registers hold
// RL17: Read 32-bit vector at base plus number
// RL18: Fetch handler address, then resume
// RL19: No automatic register saving on entry
// RL20: Handler clears freeze before re-enabling traps
// RL21: Vector number replaces base bits 9-2
// RL22: Early withdrawal ends in illegal-opcode trap
// RL23: Handler status keeps bits 31-11, bits 10-0 forced to parameter pattern
module tepb_trap_entry (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave, byte address
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Pipeline stage entries
  input  wire logic        decode_enter,
  input  wire logic [31:0] decode_addr,
  input  wire logic        execute_enter,
  input  wire logic [31:0] execute_addr,
  input  wire logic        writeback_enter,
  input  wire logic [31:0] writeback_addr,
  // Exception causes
  input  wire logic        tlb_miss_req,
  input  wire logic        tlb_miss_data,
  input  wire logic        tlb_miss_supervisor,
  input  wire logic        mmu_prot_req,
  input  wire logic        mmu_prot_data,
  input  wire logic [3:0]  interrupt_request_inputs_n,
  input  wire logic [1:0]  trap_request_inputs_n,
  input  wire logic        peripheral_irq,
  input  wire logic        emul_req,
  input  wire logic [7:0]  emul_opcode,
  input  wire logic        instr_trap_req,
  input  wire logic [7:0]  instr_trap_vector,
  // Pipeline and memory control
  input  wire logic        mem_busy,
  output logic             exec_suspend,
  output logic             fetch_suspend,
  output logic             multiple_cancel,
  output logic             vec_rd_req,
  output logic      [31:0] vec_rd_addr,
  input  wire logic        vec_rd_ack,
  input  wire logic [31:0] vec_rd_data,
  output logic             fetch_start,
  output logic      [31:0] fetch_addr,
  output logic             freeze_bit,
  output logic      [31:0] restart_first_addr,
  output logic      [31:0] restart_second_addr
);

  typedef struct packed {
    tepb_pkg::tepb_state_t st;
    logic [5:0]            pin_meta;
    logic [5:0]            pin_sync;
    logic [31:0]           cur_status;
    logic [31:0]           saved_status;
    logic [31:0]           vector_base;
    logic [7:0]            cause_vec;
    logic                  cause_pin;
    logic [2:0]            pin_idx;
    logic [7:0]            vec_num;
    logic [31:0]           vec_addr;
    logic                  fetch_go;
    logic [31:0]           handler_addr;
    logic                  bus_ack;
    logic [31:0]           rdata;
  } tepb_main_t;

  tepb_main_t s_reg;
  tepb_main_t s_next;

  logic [31:0] decode_pc;
  logic [31:0] execute_pc;
  logic [31:0] writeback_pc;
  logic [5:0]  bus_idx;
  logic        bus_req;
  logic        bus_wr;
  logic [5:0]  pin_active;
  logic        pin_any;
  logic [2:0]  pin_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign bus_idx = avs_address[7:2];
  assign bus_req = avs_read | avs_write;
  assign bus_wr  = avs_write & ~s_reg.bus_ack;
  assign avs_waitrequest = bus_req & ~s_reg.bus_ack;
  assign avs_readdata    = s_reg.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Program counter buffer; no live fetch counter is held or mapped  // RL9
  tepb_stage_reg u_decode_pc (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .stage_enter (decode_enter),
    .stage_addr  (decode_addr),
    .freeze_bit  (freeze_bit),
    .sw_write    (bus_wr && bus_idx == tepb_pkg::IDX_DECODE_PC),
    .sw_data     (avs_writedata),
    .value       (decode_pc)
  ); // RL10

  tepb_stage_reg u_execute_pc (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .stage_enter (execute_enter),
    .stage_addr  (execute_addr),
    .freeze_bit  (freeze_bit),
    .sw_write    (bus_wr && bus_idx == tepb_pkg::IDX_EXECUTE_PC),
    .sw_data     (avs_writedata),
    .value       (execute_pc)
  ); // RL11

  tepb_stage_reg u_writeback_pc (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .stage_enter (writeback_enter),
    .stage_addr  (writeback_addr),
    .freeze_bit  (freeze_bit),
    .sw_write    (bus_wr && bus_idx == tepb_pkg::IDX_WRITEBACK_PC),
    .sw_data     (avs_writedata),
    .value       (writeback_pc)
  ); // RL12

  // Return restarts execute address, then decode; write-back never used
  assign restart_first_addr  = execute_pc; // RL7
  assign restart_second_addr = decode_pc; // RL8

  ////////////////////////////////////////////////////////////////////////////
  // Pin requests, trap pins ahead of interrupt pins
  always_comb begin
    pin_active = s_reg.pin_sync;
    pin_active[tepb_pkg::PIN_SHARED_IDX] = s_reg.pin_sync[tepb_pkg::PIN_SHARED_IDX] | peripheral_irq;
    if (s_reg.cur_status[tepb_pkg::DA_BIT]) begin
      pin_active = '0;
    end else if (s_reg.cur_status[tepb_pkg::DI_BIT]) begin
      pin_active[3:0] = 4'h0;
    end
    pin_any = |pin_active;
    pin_sel = 3'd0;
    for (int i = tepb_pkg::PIN_COUNT - 1; i >= 0; i--) begin
      if (pin_active[i]) begin
        pin_sel = 3'(i);
      end
    end
    if (pin_active[4]) begin
      pin_sel = 3'd4;
    end
    if (pin_active[5] && !pin_active[4]) begin
      pin_sel = 3'd5;
    end
  end

  assign freeze_bit      = s_reg.cur_status[tepb_pkg::FZ_BIT];
  assign exec_suspend    = s_reg.st != tepb_pkg::TEPB_IDLE; // RL14
  assign fetch_suspend   = !(s_reg.st inside {tepb_pkg::TEPB_IDLE, tepb_pkg::TEPB_SUSP_EXEC});
  assign multiple_cancel = s_reg.st == tepb_pkg::TEPB_WAIT_MEM;
  assign vec_rd_req      = s_reg.st == tepb_pkg::TEPB_VEC_READ;
  assign vec_rd_addr     = s_reg.vec_addr;
  assign fetch_start     = s_reg.fetch_go;
  assign fetch_addr      = s_reg.handler_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_next          = s_reg;
    s_next.pin_meta = ~{trap_request_inputs_n, interrupt_request_inputs_n};
    s_next.pin_sync = s_reg.pin_meta;
    s_next.fetch_go = 1'b0;
    s_next.bus_ack  = bus_req & ~s_reg.bus_ack;

    // Registers answer one cycle after the request
    if (bus_req && !s_reg.bus_ack) begin
      s_next.rdata = 32'h0000_0000;
      if (bus_idx == tepb_pkg::IDX_VECTOR_BASE) begin
        s_next.rdata = s_reg.vector_base;
      end else if (bus_idx == tepb_pkg::IDX_SAVED_STATUS) begin
        s_next.rdata = s_reg.saved_status;
      end else if (bus_idx == tepb_pkg::IDX_CURRENT_STATUS) begin
        s_next.rdata = s_reg.cur_status;
      end else if (bus_idx == tepb_pkg::IDX_TRAP_STATE) begin
        s_next.rdata = {16'h0000, s_reg.vec_num, s_reg.st};
      end else if (bus_idx == tepb_pkg::IDX_DECODE_PC) begin
        s_next.rdata = decode_pc; // RL13
      end else if (bus_idx == tepb_pkg::IDX_EXECUTE_PC) begin
        s_next.rdata = execute_pc; // RL13
      end else if (bus_idx == tepb_pkg::IDX_WRITEBACK_PC) begin
        s_next.rdata = writeback_pc; // RL13
      end
    end
    if (bus_wr) begin
      if (bus_idx == tepb_pkg::IDX_VECTOR_BASE) begin
        s_next.vector_base = avs_writedata & tepb_pkg::VECTOR_BASE_MASK;
      end else if (bus_idx == tepb_pkg::IDX_SAVED_STATUS) begin
        s_next.saved_status = avs_writedata;
      end else if (bus_idx == tepb_pkg::IDX_CURRENT_STATUS) begin
        s_next.cur_status = avs_writedata;
      end
    end

    case (s_reg.st)
      tepb_pkg::TEPB_IDLE: begin
        s_next.cause_pin = 1'b0;
        if (mmu_prot_req) begin
          s_next.cause_vec = mmu_prot_data ? tepb_pkg::VEC_DMMU_PROT
                                           : tepb_pkg::VEC_IMMU_PROT; // RL1
          s_next.st        = tepb_pkg::TEPB_SUSP_EXEC;
        end else if (tlb_miss_req) begin
          s_next.cause_vec = tepb_pkg::VEC_TLB_BASE
                           | {6'h00, tlb_miss_supervisor, tlb_miss_data}; // RL1
          s_next.st        = tepb_pkg::TEPB_SUSP_EXEC;
        end else if (emul_req) begin
          // Below the emulated range counts as undefined
          s_next.cause_vec = (emul_opcode >= tepb_pkg::EMUL_OPCODE_FIRST)
                           ? emul_opcode - tepb_pkg::EMUL_OPCODE_OFFSET
                           : tepb_pkg::VEC_ILLEGAL; // RL3
          s_next.st        = tepb_pkg::TEPB_SUSP_EXEC;
        end else if (instr_trap_req) begin
          s_next.cause_vec = instr_trap_vector; // RL4
          s_next.st        = tepb_pkg::TEPB_SUSP_EXEC;
        end else if (pin_any) begin
          s_next.cause_vec = tepb_pkg::VEC_PIN_BASE + {5'h00, pin_sel}; // RL2
          s_next.cause_pin = 1'b1;
          s_next.pin_idx   = pin_sel;
          s_next.st        = tepb_pkg::TEPB_SUSP_EXEC;
        end
      end
      tepb_pkg::TEPB_SUSP_EXEC: begin
        s_next.st = tepb_pkg::TEPB_SUSP_FETCH; // RL14
      end
      tepb_pkg::TEPB_SUSP_FETCH: begin
        s_next.st = tepb_pkg::TEPB_WAIT_MEM; // RL14
      end
      tepb_pkg::TEPB_WAIT_MEM: begin
        if (!mem_busy) begin
          s_next.st = tepb_pkg::TEPB_COPY; // RL14
        end
      end
      tepb_pkg::TEPB_COPY: begin
        s_next.saved_status = s_reg.cur_status; // RL15
        s_next.st           = tepb_pkg::TEPB_MODIFY;
      end
      tepb_pkg::TEPB_MODIFY: begin
        // Only status changes; no other register is saved  // RL19
        s_next.cur_status = (s_reg.cur_status & tepb_pkg::HANDLER_KEEP_MASK)
                          | tepb_pkg::HANDLER_SET_MASK; // RL23
        s_next.cur_status[tepb_pkg::FZ_BIT] = 1'b1; // RL16
        // Vector fixed now; a pin gone quiet gives illegal opcode
        s_next.vec_num = s_reg.cause_vec;
        if (s_reg.cause_pin && !pin_active[s_reg.pin_idx]) begin
          s_next.vec_num = tepb_pkg::VEC_ILLEGAL; // RL5 RL22
        end
        if (s_reg.cause_vec == tepb_pkg::VEC_FP_EXCEPTION && !s_reg.cause_pin) begin
          s_next.vec_num = tepb_pkg::VEC_ILLEGAL; // RL6
        end
        s_next.vec_addr = {s_reg.vector_base[31:10], s_next.vec_num, 2'b00}; // RL21
        s_next.st       = tepb_pkg::TEPB_VEC_READ;
      end
      tepb_pkg::TEPB_VEC_READ: begin
        if (vec_rd_ack) begin
          s_next.handler_addr = {vec_rd_data[31:2], 2'b00}; // RL17
          s_next.st           = tepb_pkg::TEPB_FETCH;
        end
      end
      tepb_pkg::TEPB_FETCH: begin
        s_next.fetch_go = 1'b1; // RL18
        s_next.st       = tepb_pkg::TEPB_IDLE;
      end
      default: begin
        s_next.st = tepb_pkg::TEPB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_reg            <= '0;
      s_reg.st         <= tepb_pkg::TEPB_IDLE;
      s_reg.cur_status <= tepb_pkg::STATUS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_mmu_vector;
    s_reg.st == tepb_pkg::TEPB_IDLE && mmu_prot_req
      |=> s_reg.cause_vec == (8'h0C + {7'h00, $past(mmu_prot_data)});
  endproperty
  a_mmu_vector: assert property (p_mmu_vector) else $error("MMU vector wrong"); // RL1
  property p_pin_vector;
    s_reg.st == tepb_pkg::TEPB_IDLE && !mmu_prot_req && !tlb_miss_req && !emul_req
      && !instr_trap_req && pin_any |=> s_reg.cause_vec >= 8'h10 && s_reg.cause_vec <= 8'h15;
  endproperty
  a_pin_vector: assert property (p_pin_vector) else $error("Pin vector out of range"); // RL2
  property p_emul_vector;
    s_reg.st == tepb_pkg::TEPB_IDLE && !mmu_prot_req && !tlb_miss_req && emul_req
      && emul_opcode >= 8'hD8 |=> s_reg.cause_vec == $past(emul_opcode) - 8'hC0;
  endproperty
  a_emul_vector: assert property (p_emul_vector) else $error("Emulation vector wrong"); // RL3
  property p_withdrawn;
    s_reg.st == tepb_pkg::TEPB_MODIFY && s_reg.cause_pin && !pin_active[s_reg.pin_idx]
      |=> s_reg.vec_num == 8'h00;
  endproperty
  a_withdrawn: assert property (p_withdrawn) else $error("Withdrawn pin not illegal"); // RL5
  property p_no_fp_vector;
    s_reg.st == tepb_pkg::TEPB_VEC_READ |-> s_reg.vec_num != 8'h16 || s_reg.cause_pin;
  endproperty
  a_no_fp_vector: assert property (p_no_fp_vector) else $error("Vector 22 raised"); // RL6
  property p_freeze_hold;
    freeze_bit && !(bus_wr && bus_idx == tepb_pkg::IDX_EXECUTE_PC) |=> $stable(execute_pc);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("Execute address moved"); // RL11
  property p_low_zero;
    decode_pc[1:0] == 2'b00 && execute_pc[1:0] == 2'b00 && writeback_pc[1:0] == 2'b00;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("Low address bits set"); // RL13
  property p_order;
    s_reg.st == tepb_pkg::TEPB_SUSP_EXEC
      |=> s_reg.st == tepb_pkg::TEPB_SUSP_FETCH ##1 s_reg.st == tepb_pkg::TEPB_WAIT_MEM;
  endproperty
  a_order: assert property (p_order) else $error("Entry order broken"); // RL14
  property p_copy;
    s_reg.st == tepb_pkg::TEPB_COPY
      |=> s_reg.saved_status == $past(s_reg.cur_status) ##1 freeze_bit;
  endproperty
  a_copy: assert property (p_copy) else $error("Status copy or freeze wrong"); // RL15 RL16
  property p_vec_addr;
    vec_rd_req |-> vec_rd_addr == {s_reg.vector_base[31:10], s_reg.vec_num, 2'b00};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("Vector address wrong"); // RL21
  property p_fetch;
    vec_rd_req && vec_rd_ack
      |=> ##1 fetch_start && fetch_addr[31:2] == $past(vec_rd_data[31:2], 2)
          && fetch_addr[1:0] == 2'b00;
  endproperty
  a_fetch: assert property (p_fetch) else $error("Handler fetch wrong"); // RL18
  c_pin_entry: cover property (s_reg.st == tepb_pkg::TEPB_IDLE && pin_any ##[1:40] fetch_start);
  c_withdrawn: cover property (s_reg.st == tepb_pkg::TEPB_MODIFY && s_reg.cause_pin
                               && !pin_active[s_reg.pin_idx]);
  c_instr_trap: cover property (s_reg.st == tepb_pkg::TEPB_IDLE && instr_trap_req
                                && !mmu_prot_req && !tlb_miss_req && !emul_req);

endmodule // tepb_trap_entry

//--- bench/tepb_pipe_mem_model.sv
`timescale 1ns/1ps
module tepb_pipe_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        exec_suspend,
  input  wire logic        vec_rd_req,
  input  wire logic [31:0] vec_rd_addr,
  input  wire logic [3:0]  mem_hold,
  input  wire logic [3:0]  ack_delay,
  output logic             mem_busy,
  output logic             vec_rd_ack,
  output logic      [31:0] vec_rd_data
);
  logic [3:0] busy_cnt;
  logic [3:0] ack_cnt;
  logic       susp_d;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_cnt   <= 4'h0;
      ack_cnt    <= 4'h0;
      susp_d     <= 1'b0;
      vec_rd_ack <= 1'b0;
    end else begin
      susp_d     <= exec_suspend;
      vec_rd_ack <= 1'b0;
      // Load caught in flight keeps memory busy a while
      if (exec_suspend && !susp_d) busy_cnt <= mem_hold;
      else if (busy_cnt != 4'h0) busy_cnt <= busy_cnt - 4'h1;
      // Slow or prompt vector answer
      if (vec_rd_req && !vec_rd_ack) begin
        if (ack_cnt == ack_delay) begin
          vec_rd_ack <= 1'b1;
          ack_cnt    <= 4'h0;
        end else begin
          ack_cnt <= ack_cnt + 4'h1;
        end
      end
    end
  end
  assign mem_busy    = busy_cnt != 4'h0;
  // Data bus shows garbage outside the answer cycle
  assign vec_rd_data = vec_rd_ack ? ~vec_rd_addr : vec_rd_addr;
endmodule // tepb_pipe_mem_model

//--- bench/trap_entry_and_pc_buffer_tb.sv
`timescale 1ns/1ps
module trap_entry_and_pc_buffer_tb;
  localparam logic [31:0] VEC_BASE_EXP = 32'h8765_4000;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        decode_enter = 1'b0, execute_enter = 1'b0, writeback_enter = 1'b0;
  logic [31:0] decode_addr = 32'h0, execute_addr = 32'h0, writeback_addr = 32'h0;
  logic        tlb_miss_req = 1'b0, tlb_miss_data = 1'b0, tlb_miss_supervisor = 1'b0;
  logic        mmu_prot_req = 1'b0, mmu_prot_data = 1'b0, peripheral_irq = 1'b0;
  logic [3:0]  interrupt_request_inputs_n = 4'hF;
  logic [1:0]  trap_request_inputs_n = 2'h3;
  logic        emul_req = 1'b0, instr_trap_req = 1'b0;
  logic [7:0]  emul_opcode = 8'h00, instr_trap_vector = 8'h00;
  logic        mem_busy, exec_suspend, fetch_suspend, multiple_cancel;
  logic        vec_rd_req, vec_rd_ack, fetch_start, freeze_bit;
  logic [31:0] vec_rd_addr, vec_rd_data, fetch_addr, restart_first_addr, restart_second_addr;
  logic [3:0]  mem_hold = 4'h1, ack_delay = 4'h0;
  logic [31:0] rd;
  int          failures = 0;
  int          cmp_count = 0;
  always #5 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////////////
  tepb_trap_entry u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .decode_enter(decode_enter), .decode_addr(decode_addr), .execute_enter(execute_enter),
    .execute_addr(execute_addr), .writeback_enter(writeback_enter),
    .writeback_addr(writeback_addr), .tlb_miss_req(tlb_miss_req), .tlb_miss_data(tlb_miss_data),
    .tlb_miss_supervisor(tlb_miss_supervisor), .mmu_prot_req(mmu_prot_req),
    .mmu_prot_data(mmu_prot_data), .interrupt_request_inputs_n(interrupt_request_inputs_n),
    .trap_request_inputs_n(trap_request_inputs_n), .peripheral_irq(peripheral_irq),
    .emul_req(emul_req), .emul_opcode(emul_opcode), .instr_trap_req(instr_trap_req),
    .instr_trap_vector(instr_trap_vector), .mem_busy(mem_busy), .exec_suspend(exec_suspend),
    .fetch_suspend(fetch_suspend), .multiple_cancel(multiple_cancel), .vec_rd_req(vec_rd_req),
    .vec_rd_addr(vec_rd_addr), .vec_rd_ack(vec_rd_ack), .vec_rd_data(vec_rd_data),
    .fetch_start(fetch_start), .fetch_addr(fetch_addr), .freeze_bit(freeze_bit),
    .restart_first_addr(restart_first_addr), .restart_second_addr(restart_second_addr));
  tepb_pipe_mem_model u_mem (.sys_clk(sys_clk), .rst_n(rst_n), .exec_suspend(exec_suspend),
    .vec_rd_req(vec_rd_req), .vec_rd_addr(vec_rd_addr), .mem_hold(mem_hold),
    .ack_delay(ack_delay), .mem_busy(mem_busy), .vec_rd_ack(vec_rd_ack),
    .vec_rd_data(vec_rd_data));
  //////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task bus(input bit wr, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      failures++;
      wrap_up;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task stg(input logic [31:0] a);
    @(posedge sys_clk);
    {decode_enter, execute_enter, writeback_enter} <= 3'h7;
    decode_addr <= a;
    execute_addr <= a + 32'h4;
    writeback_addr <= a + 32'h8;
    @(posedge sys_clk);
    {decode_enter, execute_enter, writeback_enter} <= 3'h0;
  endtask
  task set_cause(input int k, input logic [7:0] v, input bit on);
    tlb_miss_req <= on && k == 0;
    {tlb_miss_supervisor, tlb_miss_data} <= v[1:0];
    mmu_prot_req <= on && k == 1;
    mmu_prot_data <= v[0];
    interrupt_request_inputs_n <= ~((on && k == 2) ? 4'h1 << v[1:0] : 4'h0);
    trap_request_inputs_n <= ~((on && k == 3) ? 2'h1 << v[0] : 2'h0);
    emul_req <= on && k == 4;
    emul_opcode <= v;
    instr_trap_req <= on && k == 5;
    instr_trap_vector <= v;
    peripheral_irq <= on && k == 6;
  endtask
  // One trap entry; wd withdraws a pin once execution is suspended.
  // Core causes drop once taken, else a second entry follows fetch_start.
  task trap(input int k, input logic [7:0] v, input logic [7:0] ev, input bit wd);
    logic [31:0] st, pa, va;
    int n, ce, cf, cm;
    st = {8'h00, 8'(k), 16'h0000};
    pa = {16'h0000, v, 8'h13};
    mem_hold <= wd ? 4'h6 : 4'h1;
    ack_delay <= 4'(k);
    // Freeze cleared while pins stay masked, then pins enabled
    bus(1'b1, tepb_pkg::IDX_CURRENT_STATUS, st | 32'h0000_0003, rd);
    bus(1'b1, tepb_pkg::IDX_CURRENT_STATUS, st, rd);
    stg(pa);
    @(posedge sys_clk);
    set_cause(k, v, 1'b1);
    n = 0;
    ce = 0;
    cf = 0;
    cm = 0;
    va = 32'h0;
    do begin
      @(posedge sys_clk);
      n++;
      if (exec_suspend === 1'b1 && ce == 0) ce = n;
      if (fetch_suspend === 1'b1 && cf == 0) cf = n;
      if (multiple_cancel === 1'b1 && cm == 0) cm = n;
      if (vec_rd_req === 1'b1) va = vec_rd_addr;
      if ((wd || !(k inside {2, 3, 6})) && ce != 0) set_cause(k, v, 1'b0);
    end while (fetch_start !== 1'b1 && n < 80);
    if (n >= 80) begin
      failures++;
      wrap_up;
    end
    chk(va, VEC_BASE_EXP | {22'h0, ev, 2'b00});
    chk(fetch_addr, ~va & 32'hFFFF_FFFC);
    chk({31'h0, ce != 0 && ce < cf}, 32'h1);
    chk({31'h0, cf != 0 && cf < cm}, 32'h1);
    chk({31'h0, freeze_bit}, 32'h1);
    set_cause(k, v, 1'b0);
    stg(32'hFFFF_FFF0);
    chk(restart_first_addr, (pa + 32'h4) & 32'hFFFF_FFFC);
    chk(restart_second_addr, pa & 32'hFFFF_FFFC);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, tepb_pkg::IDX_DECODE_PC + 6'(i), 32'h0, rd);
      chk(rd, (pa + 32'(4 * i)) & 32'hFFFF_FFFC);
    end
    bus(1'b0, tepb_pkg::IDX_SAVED_STATUS, 32'h0, rd);
    chk(rd, st);
    bus(1'b0, tepb_pkg::IDX_CURRENT_STATUS, 32'h0, rd);
    chk(rd, (st & tepb_pkg::HANDLER_KEEP_MASK) | tepb_pkg::HANDLER_SET_MASK);
    // Let synchronised pins settle before pins are unmasked again
    repeat (6) @(posedge sys_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(1'b0, tepb_pkg::IDX_CURRENT_STATUS, 32'h0, rd);
    chk(rd, tepb_pkg::STATUS_RESET);
    bus(1'b1, 6'h3F, 32'hFFFF_FFFF, rd);
    bus(1'b0, 6'h3F, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b1, tepb_pkg::IDX_VECTOR_BASE, 32'h8765_43FF, rd);
    bus(1'b0, tepb_pkg::IDX_VECTOR_BASE, 32'h0, rd);
    chk(rd, VEC_BASE_EXP);
    bus(1'b1, tepb_pkg::IDX_CURRENT_STATUS, 32'h0, rd);
    stg(32'h0000_1237);
    bus(1'b0, tepb_pkg::IDX_DECODE_PC, 32'h0, rd);
    chk(rd, 32'h0000_1234);
    bus(1'b0, tepb_pkg::IDX_EXECUTE_PC, 32'h0, rd);
    chk(rd, 32'h0000_1238);
    bus(1'b0, tepb_pkg::IDX_WRITEBACK_PC, 32'h0, rd);
    chk(rd, 32'h0000_123C);
    $display("test reset_and_buffers done");
    for (int i = 0; i < 4; i++) trap(0, 8'(i), 8'(8 + i), 1'b0);
    trap(1, 8'h00, 8'h0C, 1'b0);
    trap(1, 8'h01, 8'h0D, 1'b0);
    for (int i = 0; i < 4; i++) trap(2, 8'(i), 8'(16 + i), 1'b0);
    trap(6, 8'h00, 8'h13, 1'b0);
    trap(3, 8'h00, 8'h14, 1'b0);
    trap(3, 8'h01, 8'h15, 1'b0);
    trap(4, 8'hD8, 8'h18, 1'b0);
    trap(4, 8'hFF, 8'h3F, 1'b0);
    trap(5, 8'h40, 8'h40, 1'b0);
    trap(5, 8'hFF, 8'hFF, 1'b0);
    trap(5, 8'h16, 8'h00, 1'b0);
    trap(2, 8'h01, 8'h00, 1'b1);
    $display("test trap_entry done");
    wrap_up;
  end
endmodule // trap_entry_and_pc_buffer_tb
